// file: design/dual_pll_clock_select.sv
// Overview of operation
// - Range 00 is 600 MHz and up, 10 below; others reserved.
// - Core clock equals bus clock times the decoded ratio.
// - Codes 4..20 give 2x..10x halves; 21..30 give 11x..20x.
// - Codes 0, 1 and 31 turn the loop off, no clocking.
// - Codes 2 and 3 bypass the loop, core from bus, 1:1.
// - Hard reset clears writable bits: primary from pins, secondary off.
// - Changeover done within three bus cycles; status shows active loop.
// - Primary is off when its field is 0 and internal bit set.
// - Pin ratio and range values are readable as read-only bits.
`timescale 1ns/1ps
`default_nettype none
`include "clk_sel_map.svh"
module dual_pll_clock_select
#(
  parameter int LOCK_CYCLES = 100
)
(
  // Clock and reset
  input  wire logic                   MCLK,
  input  wire logic                   ARST_N,
  // Strap pins for the primary loop
  input  wire logic [4:0]             RATIO_PINS,
  input  wire logic [1:0]             FREQ_RANGE_PINS,
  // Configuration write strobe and values
  input  wire logic                   CFG_WE,
  input  wire logic                   CORE_SOURCE_SELECT,
  input  wire logic                   PRIMARY_LOOP_INTERNAL_CTL,
  input  wire logic [4:0]             PRIMARY_LOOP_RATIO_FIELD,
  input  wire logic [1:0]             PRIMARY_LOOP_RANGE_FIELD,
  input  wire logic [4:0]             SECONDARY_LOOP_RATIO_FIELD,
  input  wire logic [1:0]             SECONDARY_LOOP_RANGE_FIELD,
  input  wire logic                   ERR_CLEAR,
  // Status
  output logic [4:0]                  RATIO_PINS_RD,
  output logic [1:0]                  FREQ_RANGE_PINS_RD,
  output logic                        CORE_SOURCE_STATUS,
  output clk_sel_pkg::loop_cfg_type   ACTIVE_CFG,
  output logic                        CORE_CLOCK_ENABLE,
  output logic                        BUS_RATIO_ONE_TO_ONE,
  output logic                        PRIMARY_LOCKED,
  output logic                        SECONDARY_LOCKED,
  output logic                        SELECT_ERROR
);
  import clk_sel_pkg::*;

  logic         sel_r;
  logic         pi_r;
  logic [4:0]   prim_ratio_r;
  logic [1:0]   prim_range_r;
  logic [4:0]   sec_ratio_r;
  logic [1:0]   sec_range_r;
  logic [1:0]   sw_cnt_r;
  logic         status_r;
  loop_cfg_type act_r;
  logic         err_r;
  logic [31:0]  lock0_r;
  logic [31:0]  lock1_r;
  logic [4:0]   code0;
  logic [1:0]   rng0;
  loop_cfg_type cfg0;
  loop_cfg_type cfg1;
  logic         bad_sel;

  // Decode one ratio and range code
  function automatic loop_cfg_type decode(input logic [4:0] c,
                                          input logic [1:0] r);
    loop_cfg_type d;
    d = '0;
    unique case (r)
      `RANGE_HIGH: d.range = RNG_HIGH;
      `RANGE_LOW:  d.range = RNG_LOW;
      default:     d.range = RNG_RESERVED;
    endcase
    if (c == `CODE_OFF_A || c == `CODE_OFF_B || c == `CODE_OFF_C)
      d.mode = MODE_OFF;
    else if (c == `CODE_BYP_A || c == `CODE_BYP_B)
    begin
      d.mode    = MODE_BYPASS;
      d.mult_x2 = 6'h02;
    end
    else if (c <= `CODE_HALF_HI)
    begin
      d.mode      = MODE_MULT;
      d.mult_x2   = {1'b0, c};
      d.half_step = c[0];
    end
    else
    begin
      d.mode    = MODE_MULT;
      d.mult_x2 = 6'(({1'b0, c} - 6'h0a) << 1);
    end
    return d;
  endfunction

  // Primary loop from pins unless internal control is set
  assign code0 = pi_r ? prim_ratio_r : RATIO_PINS;
  assign rng0  = pi_r ? prim_range_r : FREQ_RANGE_PINS;
  assign cfg0  = decode(code0, rng0);
  assign cfg1  = decode(sec_ratio_r, sec_range_r);

  // Configuration bits, cleared at hard reset
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      sel_r <= 1'b0;
      pi_r  <= 1'b0;
      prim_ratio_r <= `RST_RATIO;
      prim_range_r <= `RST_RANGE;
      sec_ratio_r  <= `RST_RATIO;
      sec_range_r  <= `RST_RANGE;
    end
    else if (CFG_WE)
    begin
      sel_r <= CORE_SOURCE_SELECT;
      pi_r  <= PRIMARY_LOOP_INTERNAL_CTL;
      prim_ratio_r <= PRIMARY_LOOP_RATIO_FIELD;
      prim_range_r <= PRIMARY_LOOP_RANGE_FIELD;
      sec_ratio_r  <= SECONDARY_LOOP_RATIO_FIELD;
      sec_range_r  <= SECONDARY_LOOP_RANGE_FIELD;
    end
  end

  // Lock counters restart whenever a configuration write changes a loop setting
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      lock0_r <= '0;
      lock1_r <= '0;
    end
    else
    begin
      if (CFG_WE && (decode(PRIMARY_LOOP_INTERNAL_CTL
                            ? PRIMARY_LOOP_RATIO_FIELD : RATIO_PINS,
                            PRIMARY_LOOP_INTERNAL_CTL
                            ? PRIMARY_LOOP_RANGE_FIELD
                            : FREQ_RANGE_PINS) != cfg0))
        lock0_r <= '0;
      else if (cfg0.mode == MODE_MULT && lock0_r < 32'(LOCK_CYCLES))
        lock0_r <= lock0_r + 32'h1;
      if (CFG_WE && (SECONDARY_LOOP_RATIO_FIELD != sec_ratio_r
                     || SECONDARY_LOOP_RANGE_FIELD != sec_range_r))
        lock1_r <= '0;
      else if (cfg1.mode == MODE_MULT && lock1_r < 32'(LOCK_CYCLES))
        lock1_r <= lock1_r + 32'h1;
    end
  end

  assign PRIMARY_LOCKED   = (cfg0.mode == MODE_BYPASS)
                            || (lock0_r >= 32'(LOCK_CYCLES));
  assign SECONDARY_LOCKED = (cfg1.mode == MODE_BYPASS)
                            || (lock1_r >= 32'(LOCK_CYCLES));

  // Selection would break a restriction
  always_comb
  begin
    bad_sel = 1'b0;
    if (CFG_WE && CORE_SOURCE_SELECT != sel_r)
    begin
      if (CORE_SOURCE_SELECT)
        bad_sel = (cfg1.mode == MODE_OFF) || !SECONDARY_LOCKED;
      else
        bad_sel = (cfg0.mode == MODE_OFF) || !PRIMARY_LOCKED;
      if (cfg0.half_step && cfg1.half_step)
        bad_sel = 1'b1;
    end
  end

  // Sticky error; a new event wins over the clear
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
      err_r <= 1'b0;
    else if (bad_sel)
      err_r <= 1'b1;
    else if (ERR_CLEAR)
      err_r <= 1'b0;
  end

  // Changeover completes on the third cycle after the select changes
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      sw_cnt_r <= 2'h0;
      status_r <= 1'b0;
    end
    else if (status_r == sel_r)
      sw_cnt_r <= 2'h0;
    else if (sw_cnt_r == `SWITCH_CYCLES - 2'h1)
    begin
      status_r <= sel_r;
      sw_cnt_r <= 2'h0;
    end
    else
      sw_cnt_r <= sw_cnt_r + 2'h1;
  end

  // Registered view of the active loop
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
      act_r <= '0;
    else
      act_r <= status_r ? cfg1 : cfg0;
  end

  assign RATIO_PINS_RD        = RATIO_PINS;
  assign FREQ_RANGE_PINS_RD   = FREQ_RANGE_PINS;
  assign CORE_SOURCE_STATUS   = status_r;
  assign ACTIVE_CFG           = act_r;
  assign CORE_CLOCK_ENABLE    = act_r.mode != MODE_OFF;
  assign BUS_RATIO_ONE_TO_ONE = act_r.mode == MODE_BYPASS;
  assign SELECT_ERROR         = err_r;

  switch_bound_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    $changed(sel_r) |-> ##[1:3] (status_r == sel_r))
    else $error("changeover took more than three cycles");
  err_sticky_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    bad_sel |=> err_r)
    else $error("error flag not raised");
  off_noclk_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    ((status_r ? cfg1.mode : cfg0.mode) == MODE_OFF) |=> !CORE_CLOCK_ENABLE)
    else $error("clock enabled while off");
  bypass_ratio_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    BUS_RATIO_ONE_TO_ONE |-> act_r.mult_x2 == 6'h02)
    else $error("bypass not one to one");
  pin_status_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    RATIO_PINS_RD == RATIO_PINS && FREQ_RANGE_PINS_RD == FREQ_RANGE_PINS)
    else $error("pin readback wrong");
  primary_off_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (pi_r && prim_ratio_r == 5'h00) |-> cfg0.mode == MODE_OFF)
    else $error("primary not off");
  range_low_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (sec_range_r == 2'h2) |-> cfg1.range == RNG_LOW)
    else $error("range decode wrong");
  int_mult_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (sec_ratio_r == 5'h1e) |-> cfg1.mult_x2 == 6'h28)
    else $error("20x decode wrong");
endmodule
`default_nettype wire

// file: inc/clk_sel_map.svh
`ifndef CLK_SEL_MAP_SVH
`define CLK_SEL_MAP_SVH
// Ratio code boundaries
`define CODE_OFF_A     5'h00
`define CODE_OFF_B     5'h01
`define CODE_BYP_A     5'h02
`define CODE_BYP_B     5'h03
`define CODE_HALF_LO   5'h04
`define CODE_HALF_HI   5'h14
`define CODE_INT_HI    5'h1e
`define CODE_OFF_C     5'h1f
// Range codes
`define RANGE_HIGH     2'h0
`define RANGE_LOW      2'h2
// Reset values of writable configuration
`define RST_RATIO      5'h00
`define RST_RANGE      2'h0
// Changeover bound in bus cycles
`define SWITCH_CYCLES  2'h3
`endif

// file: inc/clk_sel_pkg.sv
package clk_sel_pkg;
  typedef enum logic [1:0]
  {
    MODE_OFF    = 2'b00,
    MODE_BYPASS = 2'b01,
    MODE_MULT   = 2'b10
  } mode_type;
  typedef enum logic [1:0]
  {
    RNG_HIGH     = 2'b00,
    RNG_LOW      = 2'b01,
    RNG_RESERVED = 2'b10
  } range_type;
  // Decoded loop setting; mult_x2 is twice the multiplier
  typedef struct packed
  {
    mode_type  mode;
    range_type range;
    logic [5:0] mult_x2;
    logic       half_step;
  } loop_cfg_type;
endpackage

// file: tb/strap_model.sv
`timescale 1ns/1ps
`default_nettype none
module strap_model
(
  // Wanted board strap settings
  input  wire logic [4:0] ratio_want,
  input  wire logic [1:0] range_want,
  // Strap pins seen by the block
  output logic [4:0]      ratio_pins,
  output logic [1:0]      range_pins
);
  // Unsupported low ratios are strapped to 3x instead
  assign ratio_pins = (ratio_want inside {5'h04, 5'h05})
                      ? 5'h06 : ratio_want;
  assign range_pins = range_want;
endmodule
`default_nettype wire

// file: tb/dual_pll_clock_select_test.sv
`timescale 1ns/1ps
`default_nettype none
module dual_pll_clock_select_test;
  import clk_sel_pkg::*;
  localparam int LK = 5;
  logic MCLK = 1'b0, ARST_N = 1'b0, CFG_WE = 1'b0, ERR_CLEAR = 1'b0;
  logic CORE_SOURCE_SELECT = 1'b0, PRIMARY_LOOP_INTERNAL_CTL = 1'b0;
  logic [4:0] PRIMARY_LOOP_RATIO_FIELD = 5'h00;
  logic [4:0] SECONDARY_LOOP_RATIO_FIELD = 5'h00;
  logic [1:0] PRIMARY_LOOP_RANGE_FIELD = 2'h0;
  logic [1:0] SECONDARY_LOOP_RANGE_FIELD = 2'h0;
  logic [4:0] rw = 5'h0c;
  logic [1:0] gw = 2'h0;
  wire logic [4:0] RATIO_PINS;
  wire logic [1:0] FREQ_RANGE_PINS;
  logic [4:0] RATIO_PINS_RD;
  logic [1:0] FREQ_RANGE_PINS_RD;
  logic CORE_SOURCE_STATUS, CORE_CLOCK_ENABLE, BUS_RATIO_ONE_TO_ONE;
  logic PRIMARY_LOCKED, SECONDARY_LOCKED, SELECT_ERROR;
  loop_cfg_type ACTIVE_CFG;
  int bad_count = 0;
  int tests_run = 0;

  // Board straps and the block under test
  strap_model u_strap (.ratio_want(rw), .range_want(gw),
    .ratio_pins(RATIO_PINS), .range_pins(FREQ_RANGE_PINS));
  dual_pll_clock_select #(.LOCK_CYCLES(LK)) u_dut (.MCLK, .ARST_N,
    .RATIO_PINS, .FREQ_RANGE_PINS, .CFG_WE, .CORE_SOURCE_SELECT,
    .PRIMARY_LOOP_INTERNAL_CTL, .PRIMARY_LOOP_RATIO_FIELD,
    .PRIMARY_LOOP_RANGE_FIELD, .SECONDARY_LOOP_RATIO_FIELD,
    .SECONDARY_LOOP_RANGE_FIELD, .ERR_CLEAR, .RATIO_PINS_RD,
    .FREQ_RANGE_PINS_RD, .CORE_SOURCE_STATUS, .ACTIVE_CFG,
    .CORE_CLOCK_ENABLE, .BUS_RATIO_ONE_TO_ONE, .PRIMARY_LOCKED,
    .SECONDARY_LOCKED, .SELECT_ERROR);

  // 100 MHz clock
  always #5 MCLK = ~MCLK;

  // Expected decoded loop setting
  function automatic loop_cfg_type exp_cfg(input logic [4:0] c,
                                           input logic [1:0] g);
    exp_cfg = '0;
    exp_cfg.range = RNG_RESERVED;
    if (g == 2'h0)
      exp_cfg.range = RNG_HIGH;
    else if (g == 2'h2)
      exp_cfg.range = RNG_LOW;
    if (c < 5'h02 || c == 5'h1f)
      exp_cfg.mode = MODE_OFF;
    else if (c < 5'h04)
    begin
      exp_cfg.mode = MODE_BYPASS;
      exp_cfg.mult_x2 = 6'h02;
    end
    else
    begin
      exp_cfg.mode = MODE_MULT;
      // Half steps: code is twice the ratio; from code 21 on, 11x and up
      if (c <= 5'h14)
        exp_cfg.mult_x2 = {1'b0, c};
      else
        exp_cfg.mult_x2 = 6'h16 + {c - 5'h15, 1'b0};
      exp_cfg.half_step = (c <= 5'h14) && c[0];
    end
  endfunction

  task chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("BAD t=%0t %s", $time, m);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask

  // One configuration write; returns just after the loading edge
  task wr(input logic s, pi, input logic [4:0] pr, sr, input logic [1:0] sg);
    @(posedge MCLK);
    CFG_WE <= 1'b1;
    CORE_SOURCE_SELECT <= s;
    PRIMARY_LOOP_INTERNAL_CTL <= pi;
    PRIMARY_LOOP_RATIO_FIELD <= pr;
    SECONDARY_LOOP_RATIO_FIELD <= sr;
    SECONDARY_LOOP_RANGE_FIELD <= sg;
    @(posedge MCLK);
    CFG_WE <= 1'b0;
    #1;
  endtask

  // Source change with changeover timing check
  task sel(input logic s);
    logic o;
    o = CORE_SOURCE_STATUS;
    wr(s, PRIMARY_LOOP_INTERNAL_CTL, PRIMARY_LOOP_RATIO_FIELD,
      SECONDARY_LOOP_RATIO_FIELD, SECONDARY_LOOP_RANGE_FIELD);
    cyc(2);
    chk(CORE_SOURCE_STATUS === o, "status early");
    cyc(1);
    chk(CORE_SOURCE_STATUS === s, "status late");
    cyc(1);
  endtask

  task clr;
    chk(SELECT_ERROR === 1'b1, "error not sticky");
    @(posedge MCLK);
    ERR_CLEAR <= 1'b1;
    @(posedge MCLK);
    ERR_CLEAR <= 1'b0;
    cyc(1);
    chk(SELECT_ERROR === 1'b0, "error not cleared");
  endtask

  task t_reset;
    cyc(LK + 3);
    chk(CORE_SOURCE_STATUS === 1'b0 && SELECT_ERROR === 1'b0, "reset");
    chk(ACTIVE_CFG === exp_cfg(5'h0c, 2'h0), "pin cfg");
    chk(RATIO_PINS_RD === 5'h0c, "ratio pins rd");
    chk(FREQ_RANGE_PINS_RD === 2'h0, "range pins rd");
    $display("test reset done");
  endtask

  // Every ratio code except 4 and 5 through the idle secondary loop
  task t_sweep;
    loop_cfg_type e;
    for (int i = 0; i < 32; i++)
    begin
      if (i[4:0] inside {5'h04, 5'h05})
        continue;
      e = exp_cfg(i[4:0], i[2:1]);
      wr(1'b0, 1'b0, 5'h00, i[4:0], i[2:1]);
      cyc(LK + 3);
      sel(1'b1);
      chk(ACTIVE_CFG.mode === e.mode, "mode");
      chk(CORE_CLOCK_ENABLE === (e.mode != MODE_OFF), "clock on");
      chk(BUS_RATIO_ONE_TO_ONE === (e.mode == MODE_BYPASS), "bus 1:1");
      if (e.mode != MODE_OFF)
        chk(ACTIVE_CFG.mult_x2 === e.mult_x2, "multiplier");
      if (e.mode == MODE_MULT)
        chk(ACTIVE_CFG === e, "full cfg");
      sel(1'b0);
    end
    $display("test sweep done");
  endtask

  // Faulty selections: unlocked, half to half, off
  task t_err;
    clr;
    wr(1'b0, 1'b0, 5'h00, 5'h0c, 2'h0);
    cyc(LK + 3);
    sel(1'b1);
    chk(SELECT_ERROR === 1'b0, "good select");
    wr(1'b1, 1'b1, 5'h09, 5'h0c, 2'h0);
    chk(PRIMARY_LOCKED === 1'b0, "lock restart");
    sel(1'b0);
    clr;
    wr(1'b0, 1'b1, 5'h09, 5'h0d, 2'h0);
    cyc(LK + 3);
    chk(SECONDARY_LOCKED === 1'b1, "locked");
    sel(1'b1);
    chk(ACTIVE_CFG.half_step === 1'b1, "half step");
    clr;
    wr(1'b1, 1'b1, 5'h00, 5'h0d, 2'h0);
    cyc(LK + 3);
    sel(1'b0);
    chk(ACTIVE_CFG.mode === MODE_OFF, "primary off");
    chk(CORE_CLOCK_ENABLE === 1'b0, "off clock");
    clr;
    $display("test errors done");
  endtask

  task end_of_test;
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(posedge MCLK);
    ARST_N <= 1'b1;
    t_reset;
    t_sweep;
    t_err;
    end_of_test;
  end

  // Watchdog
  initial
  begin
    repeat (5000) @(posedge MCLK);
    bad_count++;
    end_of_test;
  end
endmodule
`default_nettype wire
